// *** logic/sps_spi_port.sv ***
// Byte-wide synchronous serial port, master or slave, 4- or 3-wire.
// Assumes pins are external and asynchronous; configuration is static
// while a transfer is in flight.
module sps_spi_port (
    input wire logic clk,
    input wire logic reset,
    input wire logic enable,
    input wire logic master_mode,
    input wire logic three_wire,
    input wire logic bidir_out,
    input wire logic cpol,
    input wire logic cpha,
    input wire logic lsb_first,
    input wire logic ss_output_en,
    input wire logic [2:0] prescale_sel,
    input wire logic [7:0] rate_sel,
    input wire logic [7:0] tx_data,
    input wire logic tx_write,
    output logic tx_ready,
    output logic [7:0] rx_data,
    output logic rx_full,
    input wire logic rx_read,
    output logic overrun,
    input wire logic overrun_clear,
    output logic busy,
    input wire logic serial_bit_clock_pin_in,
    output logic serial_bit_clock_pin_out,
    output logic serial_bit_clock_pin_oe,
    input wire logic slave_select_n_in,
    output logic slave_select_n_out,
    output logic slave_select_n_oe,
    input wire logic master_bidir_data_pin_in,
    output logic master_bidir_data_pin_out,
    output logic master_bidir_data_pin_oe,
    input wire logic slave_bidir_data_pin_in,
    output logic slave_bidir_data_pin_out,
    output logic slave_bidir_data_pin_oe
);
    sps_rate_if rif ();

    sps_bit_rate_div u_div (
        .clk(clk),
        .reset(reset),
        .rif(rif)
    );

    sps_pkg::sps_state_t state, next_state;
    logic [7:0] sh, next_sh;
    logic [7:0] tx_hold, next_tx_hold;
    logic tx_full, next_tx_full;
    logic [7:0] next_rx_data;
    logic next_rx_full;
    logic next_overrun;
    logic [3:0] edge_cnt, next_edge_cnt;
    logic [3:0] bit_cnt, next_bit_cnt;
    logic dout, next_dout;
    logic sclk, next_sclk;
    logic ss_act, next_ss_act;
    logic [2:0] sclk_sync;
    logic [1:0] ss_sync;
    logic [1:0] mdat_sync;
    logic [1:0] sdat_sync;
    logic din;
    logic ev;
    logic ev_lead;
    logic sample_ev;
    logic drive_ev;
    logic selected;
    logic [7:0] shifted;

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (reset) begin
            sclk_sync <= 3'h0;
            ss_sync <= 2'h3;
            mdat_sync <= 2'h0;
            sdat_sync <= 2'h0;
        end else begin
            sclk_sync <= {sclk_sync[1:0], serial_bit_clock_pin_in};
            ss_sync <= {ss_sync[0], slave_select_n_in};
            mdat_sync <= {mdat_sync[0], master_bidir_data_pin_in};
            sdat_sync <= {sdat_sync[0], slave_bidir_data_pin_in};
        end
    end

    // ------------------------------------------------------------
    // Pin direction and drive
    // ------------------------------------------------------------
    always_comb begin
        selected = !master_mode && !ss_sync[1] && enable;
        if (master_mode) begin
            din = three_wire ? mdat_sync[1] : sdat_sync[1];
        end else begin
            din = three_wire ? sdat_sync[1] : mdat_sync[1];
        end
        serial_bit_clock_pin_out = sclk;
        serial_bit_clock_pin_oe = enable && master_mode;
        slave_select_n_out = !ss_act;
        slave_select_n_oe = enable && master_mode && ss_output_en;
        master_bidir_data_pin_out = dout;
        slave_bidir_data_pin_out = dout;
        // One driver at a time on the shared line.
        master_bidir_data_pin_oe = enable && master_mode
            && (!three_wire || bidir_out);
        slave_bidir_data_pin_oe = selected
            && (!three_wire || bidir_out);
        rif.prescale_sel = prescale_sel;
        rif.rate_sel = rate_sel;
        rif.run = master_mode && enable && (state != sps_pkg::ST_IDLE);
        tx_ready = !tx_full;
        busy = state != sps_pkg::ST_IDLE;
    end

    // ------------------------------------------------------------
    // Transfer engine
    // ------------------------------------------------------------
    always_comb begin
        next_state = state;
        next_sh = sh;
        next_tx_hold = tx_hold;
        next_tx_full = tx_full;
        next_rx_data = rx_data;
        next_edge_cnt = edge_cnt;
        next_bit_cnt = bit_cnt;
        next_dout = dout;
        next_sclk = sclk;
        next_ss_act = ss_act;
        ev = 1'b0;
        ev_lead = 1'b0;
        if (master_mode) begin
            ev = (state == sps_pkg::ST_SHIFT) && rif.tick;
            ev_lead = !edge_cnt[0];
        end else if (selected && state == sps_pkg::ST_SHIFT) begin
            ev = sclk_sync[1] != sclk_sync[2];
            ev_lead = sclk_sync[2] == cpol;
        end
        sample_ev = ev && (ev_lead ^ cpha);
        drive_ev = ev && !(ev_lead ^ cpha);
        shifted = sps_pkg::shift_in(sh, din, lsb_first);
        // Read and write of the holding buffers; a new byte wins.
        next_rx_full = rx_full && !rx_read;
        next_overrun = overrun && !overrun_clear;
        if (tx_write && !tx_full) begin
            next_tx_hold = tx_data;
            next_tx_full = 1'b1;
        end
        if (drive_ev) begin
            next_dout = sps_pkg::top_bit(sh, lsb_first);
        end
        if (sample_ev) begin
            next_sh = shifted;
            next_bit_cnt = bit_cnt + 4'h1;
            if (bit_cnt == sps_pkg::LAST_BIT) begin
                next_bit_cnt = 4'h0;
                next_rx_data = shifted;
                next_rx_full = 1'b1;
                next_overrun = next_overrun || (rx_full && !rx_read);
                if (!master_mode && tx_full) begin
                    next_sh = tx_hold;
                    next_tx_full = 1'b0;
                end
            end
        end
        if (ev && master_mode) begin
            next_sclk = !sclk;
            next_edge_cnt = edge_cnt + 4'h1;
        end
        unique case (state)
            sps_pkg::ST_IDLE: begin
                next_sclk = cpol;
                next_ss_act = 1'b0;
                next_edge_cnt = 4'h0;
                next_bit_cnt = 4'h0;
                if ((master_mode && enable && tx_full) || selected) begin
                    next_sh = tx_hold;
                    next_dout = sps_pkg::top_bit(tx_hold, lsb_first);
                    next_tx_full = 1'b0;
                    next_ss_act = master_mode;
                    next_state = master_mode ? sps_pkg::ST_LEAD
                                             : sps_pkg::ST_SHIFT;
                end
            end
            sps_pkg::ST_LEAD: begin
                if (rif.tick) begin
                    next_state = sps_pkg::ST_SHIFT;
                end
            end
            sps_pkg::ST_SHIFT: begin
                if (master_mode && ev && edge_cnt == sps_pkg::LAST_EDGE) begin
                    next_state = sps_pkg::ST_TRAIL;
                end
                if (!master_mode && !selected) begin
                    next_state = sps_pkg::ST_IDLE;
                end
            end
            sps_pkg::ST_TRAIL: begin
                if (rif.tick) begin
                    next_ss_act = 1'b0;
                    next_state = sps_pkg::ST_IDLE;
                end
            end
        endcase
        if (!enable) begin
            next_state = sps_pkg::ST_IDLE;
            next_ss_act = 1'b0;
            next_sclk = cpol;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            state <= sps_pkg::ST_IDLE;
            sh <= sps_pkg::DATA_RESET;
            tx_hold <= sps_pkg::DATA_RESET;
            tx_full <= 1'b0;
            rx_data <= sps_pkg::DATA_RESET;
            rx_full <= 1'b0;
            overrun <= 1'b0;
            edge_cnt <= 4'h0;
            bit_cnt <= 4'h0;
            dout <= 1'b0;
            sclk <= 1'b0;
            ss_act <= 1'b0;
        end else begin
            state <= next_state;
            sh <= next_sh;
            tx_hold <= next_tx_hold;
            tx_full <= next_tx_full;
            rx_data <= next_rx_data;
            rx_full <= next_rx_full;
            overrun <= next_overrun;
            edge_cnt <= next_edge_cnt;
            bit_cnt <= next_bit_cnt;
            dout <= next_dout;
            sclk <= next_sclk;
            ss_act <= next_ss_act;
        end
    end
endmodule // sps_spi_port

// *** logic/sps_pkg.sv ***
// Constants, state codes and helpers for the serial port block.
// Assumes a single 20 MHz clock with synchronous active-high reset.
//
// Summary of operation
// - Each transfer shifts one byte both ways.
// - Four pins: clock, out data, in data, select.
// - Configuration picks master or slave role.
// - Three-wire master: master data pin bidirectional.
// - Three-wire slave: slave data pin bidirectional.
// - Shared data line drives one direction only.
// - Bit clock: prescaler to eight, divider to 256.
// - Bit rate never above 8 MHz.
// - Separate transmit and receive holding buffers.
// - Selectable clock polarity and phase, four combinations.
// - Master optionally drives select, else floats it.
// - Selectable MSB-first or LSB-first bit order.
package sps_pkg;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_HZ = 20_000_000;
    localparam int MAX_BIT_RATE_HZ = 8_000_000;
    localparam int MIN_HALF_CYCLES =
        (CLK_HZ + 2 * MAX_BIT_RATE_HZ - 1) / (2 * MAX_BIT_RATE_HZ);
    localparam int PRESCALE_MAX = 8;
    localparam int RATE_MAX = 256;

    // ------------------------------------------------------------
    // Framing
    // ------------------------------------------------------------
    localparam int BYTE_BITS = 8;
    localparam logic [3:0] LAST_EDGE = 4'h0F;
    localparam logic [3:0] LAST_BIT = 4'h7;
    localparam logic [7:0] DATA_RESET = 8'h00;

    // ------------------------------------------------------------
    // States
    // ------------------------------------------------------------
    typedef enum logic [3:0] {
        ST_IDLE = 4'b0001,
        ST_LEAD = 4'b0010,
        ST_SHIFT = 4'b0100,
        ST_TRAIL = 4'b1000
    } sps_state_t;

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic top_bit(input logic [7:0] sh,
                                     input logic lsb_first);
        top_bit = lsb_first ? sh[0] : sh[7];
    endfunction

    function automatic logic [7:0] shift_in(input logic [7:0] sh,
                                            input logic b,
                                            input logic lsb_first);
        shift_in = lsb_first ? {b, sh[7:1]} : {sh[6:0], b};
    endfunction

endpackage

// *** logic/sps_rate_if.sv ***
// Link between the port core and its bit-rate divider.
// Assumes both ends run on the same clock.
interface sps_rate_if;
    logic [2:0] prescale_sel;
    logic [7:0] rate_sel;
    logic run;
    logic tick;

    modport divider (
        input prescale_sel,
        input rate_sel,
        input run,
        output tick
    );

    modport core (
        output prescale_sel,
        output rate_sel,
        output run,
        input tick
    );
endinterface

// *** logic/sps_bit_rate_div.sv ***
// Two-stage divider that gives one half-bit enable pulse.
// Assumes run is held high for the whole of a master transfer.
module sps_bit_rate_div (
    input wire logic clk,
    input wire logic reset,
    sps_rate_if.divider rif
);
    logic [2:0] pre_cnt;
    logic [7:0] rate_cnt;
    logic [3:0] guard;
    logic pending;
    logic [2:0] next_pre_cnt;
    logic [7:0] next_rate_cnt;
    logic [3:0] next_guard;
    logic next_pending;
    logic pre_tick;
    logic terminal;
    logic allowed;

    // ------------------------------------------------------------
    // Prescaler, rate divider and rate guard
    // ------------------------------------------------------------
    always_comb begin
        pre_tick = (pre_cnt == rif.prescale_sel);
        terminal = pre_tick && (rate_cnt == rif.rate_sel);
        allowed = guard >= 4'(sps_pkg::MIN_HALF_CYCLES - 1);
        rif.tick = rif.run && (terminal || pending) && allowed;
        next_pre_cnt = pre_tick ? 3'h0 : pre_cnt + 3'h1;
        next_rate_cnt = rate_cnt;
        if (terminal) begin
            next_rate_cnt = 8'h00;
        end else if (pre_tick) begin
            next_rate_cnt = rate_cnt + 8'h01;
        end
        next_pending = (pending || terminal) && !rif.tick;
        next_guard = (guard == 4'hF) ? guard : guard + 4'h1;
        if (rif.tick) begin
            next_guard = 4'h0;
        end
        if (!rif.run) begin
            next_pre_cnt = 3'h0;
            next_rate_cnt = 8'h00;
            next_pending = 1'b0;
            next_guard = 4'hF;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            pre_cnt <= 3'h0;
            rate_cnt <= 8'h00;
            guard <= 4'hF;
            pending <= 1'b0;
        end else begin
            pre_cnt <= next_pre_cnt;
            rate_cnt <= next_rate_cnt;
            guard <= next_guard;
            pending <= next_pending;
        end
    end
endmodule // sps_bit_rate_div

// *** test/sps_checker.sv ***
// Checker for the serial port: pins, buffers and byte framing.
// Assumes it is bound to sps_spi_port and sees only its ports.
module sps_checker (
    input wire logic clk,
    input wire logic reset,
    input wire logic enable,
    input wire logic master_mode,
    input wire logic three_wire,
    input wire logic bidir_out,
    input wire logic cpol,
    input wire logic ss_output_en,
    input wire logic [2:0] prescale_sel,
    input wire logic [7:0] rate_sel,
    input wire logic tx_write,
    input wire logic tx_ready,
    input wire logic rx_full,
    input wire logic overrun,
    input wire logic busy,
    input wire logic serial_bit_clock_pin_out,
    input wire logic serial_bit_clock_pin_oe,
    input wire logic slave_select_n_out,
    input wire logic slave_select_n_oe,
    input wire logic master_bidir_data_pin_oe,
    input wire logic slave_bidir_data_pin_oe
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [11:0] half;
    logic [11:0] gap;
    logic [4:0] edges;
    default clocking @(posedge clk);
    endclocking
    default disable iff (reset);
    // --------------------------------------------------
    // Bit clock spacing and edge count
    // --------------------------------------------------
    assign half = ({9'h000, prescale_sel} + 12'h001)
        * ({4'h0, rate_sel} + 12'h001);
    always_ff @(posedge clk) begin
        if (reset || !busy) begin
            edges <= 5'h00;
        end else if ($changed(serial_bit_clock_pin_out)) begin
            edges <= edges + 5'h01;
        end
        if ($changed(serial_bit_clock_pin_out)) begin
            gap <= 12'h000;
        end else if (gap != 12'hfff) begin
            gap <= gap + 12'h001;
        end
    end
    // --------------------------------------------------
    // Properties
    // --------------------------------------------------
    sequence s_tx_take;
        tx_write && tx_ready;
    endsequence
    sequence s_start;
        !tx_ready ##1 busy;
    endsequence
    sequence s_sel_fall;
        master_mode && ss_output_en && $fell(slave_select_n_out);
    endsequence
    property p_start;
        (enable && master_mode && !busy) ##0 s_tx_take |=> s_start;
    endproperty
    property p_gap;
        busy && master_mode && edges != 5'h00
            && $changed(serial_bit_clock_pin_out)
            |-> gap == ((half < 12'h002) ? 12'h001 : half - 12'h001);
    endproperty
    property p_sixteen;
        master_mode && enable && $fell(busy) |-> edges == 5'h10;
    endproperty
    property p_sel_lead;
        s_sel_fall |-> $stable(serial_bit_clock_pin_out) [*2];
    endproperty
    property p_sel_hold;
        master_mode && ss_output_en && busy
            && $changed(serial_bit_clock_pin_out) |-> !slave_select_n_out;
    endproperty
    property p_idle;
        master_mode && enable && !busy && !$past(busy) && !$past(reset)
            && $stable(cpol) && $stable(master_mode) && $stable(enable)
            |-> serial_bit_clock_pin_out == cpol;
    endproperty
    property p_clk_oe;
        serial_bit_clock_pin_oe == (enable && master_mode);
    endproperty
    property p_sel_oe;
        slave_select_n_oe == (enable && master_mode && ss_output_en);
    endproperty
    property p_overrun;
        $rose(overrun) |-> $past(rx_full);
    endproperty
    property p_tw_master;
        enable && master_mode && three_wire && !bidir_out
            |-> !master_bidir_data_pin_oe;
    endproperty
    property p_tw_slave;
        enable && !master_mode && three_wire && !bidir_out
            |-> !slave_bidir_data_pin_oe;
    endproperty
    a_start: assert property (p_start) else $error("start late");
    a_gap: assert property (p_gap) else $error("clock spacing");
    a_sixteen: assert property (p_sixteen) else $error("edge count");
    a_sel_lead: assert property (p_sel_lead) else $error("select");
    a_sel_hold: assert property (p_sel_hold) else $error("select");
    a_idle: assert property (p_idle) else $error("idle level");
    a_clk_oe: assert property (p_clk_oe) else $error("clock oe");
    a_sel_oe: assert property (p_sel_oe) else $error("select oe");
    a_overrun: assert property (p_overrun) else $error("overrun");
    a_tw_master: assert property (p_tw_master) else $error("oe");
    a_tw_slave: assert property (p_tw_slave) else $error("oe");
endmodule // sps_checker

// *** test/sps_slave_model.sv ***
// Behavioural far-side device facing the port in master role.
// Assumes mode inputs stay steady while a byte is in flight.
module sps_slave_model (
    input wire logic active,
    input wire logic sclk,
    input wire logic ss_n,
    input wire logic mosi,
    input wire logic cpol,
    input wire logic cpha,
    input wire logic lsb_first,
    input wire logic [7:0] tx_byte,
    output logic miso,
    output logic [7:0] rx_byte
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] sh = 8'h00;
    int n = 0;
    initial miso = 1'b0;
    initial rx_byte = 8'h00;
    always @(negedge ss_n) begin
        if (active) begin
            sh = tx_byte;
            n = 0;
            miso = tx_byte[lsb_first ? 0 : 7];
        end
    end
    always @(posedge ss_n) miso = !miso;
    always @(sclk) begin
        if (active && !ss_n) begin
            if ((sclk != cpol) ^ cpha) begin
                rx_byte[lsb_first ? n : 7 - n] = mosi;
                n = (n + 1) % 8;
            end else begin
                miso = sh[lsb_first ? n : 7 - n];
            end
        end
    end
endmodule // sps_slave_model

// *** test/tb.sv ***
// Self-checking bench for the serial port in both roles.
// Assumes the checker and the far-side model are compiled first.
bind sps_spi_port sps_checker u_chk (.clk, .reset, .enable, .master_mode,
    .three_wire, .bidir_out, .cpol, .ss_output_en, .prescale_sel,
    .rate_sel, .tx_write, .tx_ready, .rx_full, .overrun, .busy,
    .serial_bit_clock_pin_out, .serial_bit_clock_pin_oe,
    .slave_select_n_out, .slave_select_n_oe, .master_bidir_data_pin_oe,
    .slave_bidir_data_pin_oe);
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic enable, master_mode, three_wire, bidir_out, cpol, cpha, lsb_first;
    logic ss_output_en, tx_write, rx_read, overrun_clear, tb_sclk, tb_ss_n;
    logic tb_mosi, mdl_on, tx_ready, rx_full, overrun, busy, mdl_miso;
    logic ck_o, ck_oe, ss_o, ss_oe, m_o, m_oe, s_o, s_oe;
    logic [2:0] prescale_sel;
    logic [7:0] rate_sel, tx_data, rx_data, mdl_tx, mdl_rx;
    int mismatches = 0;
    int n_tests = 0;
    wire sclk_w = ck_oe ? ck_o : tb_sclk;
    wire ss_w = ss_oe ? ss_o : tb_ss_n;
    wire mosi_w = m_oe ? m_o : tb_mosi;
    wire miso_w = s_oe ? s_o : mdl_miso;
    sps_spi_port u_dut (.clk, .reset, .enable, .master_mode, .three_wire,
        .bidir_out, .cpol, .cpha, .lsb_first, .ss_output_en, .prescale_sel,
        .rate_sel, .tx_data, .tx_write, .tx_ready, .rx_data, .rx_full,
        .rx_read, .overrun, .overrun_clear, .busy,
        .serial_bit_clock_pin_in(sclk_w), .serial_bit_clock_pin_out(ck_o),
        .serial_bit_clock_pin_oe(ck_oe), .slave_select_n_in(ss_w),
        .slave_select_n_out(ss_o), .slave_select_n_oe(ss_oe),
        .master_bidir_data_pin_in(mosi_w), .master_bidir_data_pin_out(m_o),
        .master_bidir_data_pin_oe(m_oe), .slave_bidir_data_pin_in(miso_w),
        .slave_bidir_data_pin_out(s_o), .slave_bidir_data_pin_oe(s_oe));
    sps_slave_model u_mdl (.active(mdl_on), .sclk(sclk_w), .ss_n(ss_w),
        .mosi(mosi_w), .cpol, .cpha, .lsb_first, .tx_byte(mdl_tx),
        .miso(mdl_miso), .rx_byte(mdl_rx));
    always #25 clk = ~clk;
    // --------------------------------------------------
    // Shared tasks
    // --------------------------------------------------
    task automatic tally_and_finish();
        if (mismatches == 0 && n_tests > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp) begin
            mismatches++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic put(input logic [7:0] d);
        tx_data = d;
        tx_write = 1'b1;
        @(negedge clk);
        tx_write = 1'b0;
    endtask
    task automatic take();
        rx_read = 1'b1;
        overrun_clear = 1'b1;
        @(negedge clk);
        rx_read = 1'b0;
        overrun_clear = 1'b0;
    endtask
    task automatic wait_for(input logic ovr);
        int i;
        for (i = 0; i < 1000; i++) begin
            if ((ovr ? overrun : rx_full) === 1'b1 && busy === 1'b0
                && tx_ready === 1'b1) break;
            @(negedge clk);
        end
        if (i == 1000) begin
            mismatches++;
            tally_and_finish();
        end
    endtask
    function automatic int bi(input int k);
        return lsb_first ? k : 7 - k;
    endfunction
    task automatic ext_byte(input logic [7:0] d, output logic [7:0] got);
        int k;
        got = 8'h00;
        tb_sclk = cpol;
        #13;
        tb_ss_n = 1'b0;
        tb_mosi = d[bi(0)];
        #400;
        for (k = 0; k < 8; k++) begin
            if (cpha) tb_mosi = d[bi(k)];
            else got[bi(k)] = miso_w;
            tb_sclk = !tb_sclk;
            #200;
            if (cpha) got[bi(k)] = miso_w;
            else tb_mosi = d[bi((k + 1) % 8)];
            tb_sclk = !tb_sclk;
            #200;
        end
        tb_ss_n = 1'b1;
        tb_mosi = !tb_mosi;
        #37;
    endtask
    // --------------------------------------------------
    // Scenarios
    // --------------------------------------------------
    task automatic master_modes();
        int m;
        for (m = 0; m < 8; m++) begin
            {lsb_first, cpol, cpha} = m[2:0];
            ss_output_en = m[0] ^ m[1];
            repeat (2) @(negedge clk);
            mdl_tx = 8'h3c + m[7:0];
            tb_ss_n = 1'b0;
            put(8'ha5 ^ m[7:0]);
            repeat (3) @(negedge clk);
            check({7'h00, ss_oe}, {7'h00, ss_output_en});
            wait_for(1'b0);
            tb_ss_n = 1'b1;
            check(rx_data, 8'h3c + m[7:0]);
            check(mdl_rx, 8'ha5 ^ m[7:0]);
            take();
        end
    endtask
    task automatic overrun_refuse();
        int i;
        mdl_tx = 8'h5a;
        tb_ss_n = 1'b0;
        tx_data = 8'h81;
        tx_write = 1'b1;
        @(negedge clk);
        tx_data = 8'hee;
        @(negedge clk);
        tx_write = 1'b0;
        for (i = 0; i < 20 && tx_ready !== 1'b1; i++) @(negedge clk);
        check({7'h00, busy}, 8'h01);
        put(8'h42);
        wait_for(1'b1);
        tb_ss_n = 1'b1;
        check(rx_data, 8'h5a);
        check(mdl_rx, 8'h42);
        take();
        check({6'h00, rx_full, overrun}, 8'h00);
    endtask
    task automatic slave_modes();
        int m;
        logic [7:0] got;
        master_mode = 1'b0;
        mdl_on = 1'b0;
        for (m = 0; m < 8; m++) begin
            {lsb_first, cpol, cpha} = m[2:0];
            put(8'hc3 ^ m[7:0]);
            ext_byte(8'h96 + m[7:0], got);
            wait_for(1'b0);
            check(got, 8'hc3 ^ m[7:0]);
            check(rx_data, 8'h96 + m[7:0]);
            take();
        end
    endtask
    task automatic three_wire_dirs();
        int m;
        three_wire = 1'b1;
        for (m = 3; m >= 0; m--) begin
            {master_mode, bidir_out} = m[1:0];
            tb_ss_n = m[1];
            repeat (4) @(negedge clk);
            check({6'h00, m_oe, s_oe}, {6'h00, m[1] & m[0], !m[1] & m[0]});
        end
        tb_ss_n = 1'b1;
    endtask
    initial begin
        {enable, three_wire, bidir_out, cpol, cpha, lsb_first} = 6'h00;
        {ss_output_en, tx_write, rx_read, overrun_clear, tb_sclk} = 5'h00;
        {master_mode, mdl_on, tb_ss_n, tb_mosi} = 4'he;
        prescale_sel = 3'h1;
        rate_sel = 8'h03;
        tx_data = 8'h00;
        mdl_tx = 8'h00;
        repeat (4) @(negedge clk);
        reset = 1'b0;
        enable = 1'b1;
        @(negedge clk);
        check({3'h0, tx_ready, rx_full, overrun, busy, ss_o}, 8'h11);
        master_modes();
        overrun_refuse();
        slave_modes();
        three_wire_dirs();
        tally_and_finish();
    end
endmodule // tb
